// ---- nsc_cfg.svh ----
`ifndef NSC_CFG_SVH
`define NSC_CFG_SVH
// ----------------------------------------
// characters
// ----------------------------------------
`define NSC_CH_DOLLAR 8'h24
`define NSC_CH_STAR   8'h2a
`define NSC_CH_COMMA  8'h2c
`define NSC_CH_CR     8'h0d
`define NSC_CH_LF     8'h0a
`define NSC_CH_ZERO   8'h30
// talker string, arbitrary neutral value
`define NSC_TALKER    32'h5850_5254
// ----------------------------------------
// limits and timing
// ----------------------------------------
`define NSC_MAX_LEN   255
`define NSC_CLK_MHZ   50
`define NSC_TD_MIN_MS 100
`define NSC_TD_MAX_MS 500
`define NSC_TD_MIN_CYC (`NSC_TD_MIN_MS * 1000 * `NSC_CLK_MHZ)
`define NSC_TD_MAX_CYC (`NSC_TD_MAX_MS * 1000 * `NSC_CLK_MHZ)
// ----------------------------------------
// packet types
// ----------------------------------------
`define NSC_PT_TEST   10'd0
`define NSC_PT_ACK    10'd1
`define NSC_PT_SYSMSG 10'd10
`define NSC_PT_OUTSET 10'd314
`define NSC_PT_FWQRY  10'd605
`define NSC_PT_FWINFO 10'd705
// ack result flags
`define NSC_F_INVALID 2'h0
`define NSC_F_UNSUPP  2'h1
`define NSC_F_FAIL    2'h2
`define NSC_F_OK      2'h3
`endif

// ---- nsc_pkg.sv ----
package nsc_pkg;
  // receive parser states
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0000,
    RX_TALK  = 4'b0001,
    RX_TYPE  = 4'b0010,
    RX_DATA  = 4'b0011,
    RX_CK_HI = 4'b0100,
    RX_CK_LO = 4'b0101,
    RX_CR    = 4'b0110,
    RX_LF    = 4'b0111
  } nsc_rx_t;
  // transmit job kinds
  typedef enum logic [2:0] {
    JOB_NONE = 3'b000,
    JOB_ACK  = 3'b001,
    JOB_FW   = 3'b010,
    JOB_VTG  = 3'b011,
    JOB_ZDA  = 3'b100
  } nsc_job_t;
endpackage

// ---- nsc_port.sv ----
`timescale 1ns/10ps
`include "nsc_cfg.svh"
module nsc_port #(
  parameter int TD_MIN = `NSC_TD_MIN_CYC,
  parameter int TD_MAX = `NSC_TD_MAX_CYC,
  parameter int FWLEN  = 4
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // received bytes
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  // transmitted bytes
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  // navigation data, ascii fields
  input  wire logic        fix_valid,
  input  wire logic [7:0]  mode_char,
  input  wire logic [39:0] course_true,
  input  wire logic [39:0] course_mag,
  input  wire logic [39:0] speed_knots,
  input  wire logic [39:0] speed_kmh,
  input  wire logic [71:0] utc_time,
  input  wire logic [71:0] gps_time,
  input  wire logic        utc_known,
  input  wire logic [15:0] day_chars,
  input  wire logic [15:0] month_chars,
  input  wire logic [31:0] year_chars,
  input  wire logic        pulse_per_second,
  input  wire logic [8*FWLEN-1:0] fw_chars,
  // output rate settings
  output logic      [7:0]  rate_track,
  output logic      [7:0]  rate_time
);
  import nsc_pkg::*;

  // ----------------------------------------
  // receive parser
  // ----------------------------------------
  nsc_rx_t     rx_st;
  logic [7:0]  rx_len;
  logic [7:0]  rx_sum;
  logic [7:0]  rx_ck;
  logic [2:0]  rx_cnt;
  logic [31:0] rx_talk;
  logic [9:0]  rx_type;
  logic [3:0]  rx_fld;
  logic [7:0]  rx_p0;
  logic [7:0]  rx_p1;
  logic        rx_bad;
  logic        pkt_done;
  logic        len_over;
  logic        is_digit;
  logic [3:0]  hexval;
  logic [3:0]  dval;

  assign is_digit = (rx_data >= `NSC_CH_ZERO) && (rx_data <= 8'h39);
  assign dval     = 4'(rx_data - `NSC_CH_ZERO);
  assign len_over = (rx_len == 8'(`NSC_MAX_LEN));
  // uppercase hex digit decode
  always_comb begin
    if (is_digit)
      hexval = dval;
    else
      hexval = 4'(rx_data - 8'h37);
  end

  // parser state machine
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rx_st    <= RX_IDLE;
      rx_len   <= 8'h00;
      rx_sum   <= 8'h00;
      rx_ck    <= 8'h00;
      rx_cnt   <= 3'h0;
      rx_talk  <= 32'h0;
      rx_type  <= 10'h000;
      rx_fld   <= 4'h0;
      rx_p0    <= 8'h00;
      rx_p1    <= 8'h00;
      rx_bad   <= 1'b0;
      pkt_done <= 1'b0;
    end else begin
      pkt_done <= 1'b0;
      if (rx_valid) begin
        rx_len <= len_over ? rx_len : rx_len + 8'h01;
        if (len_over)
          rx_bad <= 1'b1;
        if (rx_st != RX_IDLE && rx_data != `NSC_CH_STAR && rx_st <= RX_DATA)
          rx_sum <= rx_sum ^ rx_data;
        if (rx_data == `NSC_CH_DOLLAR) begin
          rx_st   <= RX_TALK;
          rx_len  <= 8'h01;
          rx_sum  <= 8'h00;
          rx_cnt  <= 3'h0;
          rx_type <= 10'h000;
          rx_fld  <= 4'h0;
          rx_bad  <= 1'b0;
        end else begin
          case (rx_st)
            RX_IDLE: begin
              rx_st <= RX_IDLE;
            end
            RX_TALK: begin
              rx_talk <= {rx_talk[23:0], rx_data};
              rx_cnt  <= rx_cnt + 3'h1;
              if (rx_cnt == 3'h3)
                rx_st <= RX_TYPE;
            end
            RX_TYPE: begin
              if (!is_digit)
                rx_bad <= 1'b1;
              rx_type <= 10'(rx_type * 10'd10 + 10'(dval));
              rx_cnt  <= rx_cnt + 3'h1;
              if (rx_cnt == 3'h6)
                rx_st <= RX_DATA;
              if (rx_talk != `NSC_TALKER)
                rx_bad <= 1'b1;
            end
            RX_DATA: begin
              if (rx_data == `NSC_CH_STAR) begin
                rx_st <= RX_CK_HI;
              end else if (rx_data == `NSC_CH_COMMA) begin
                if (rx_fld != 4'hf)
                  rx_fld <= rx_fld + 4'h1;
              end else if (rx_fld == 4'h0) begin
                rx_bad <= 1'b1;
              end else if (rx_fld == 4'h1) begin
                rx_p0 <= rx_data;
              end else if (rx_fld == 4'h2) begin
                rx_p1 <= rx_data;
              end
            end
            RX_CK_HI: begin
              rx_ck[7:4] <= hexval;
              rx_st      <= RX_CK_LO;
            end
            RX_CK_LO: begin
              rx_ck[3:0] <= hexval;
              rx_st      <= RX_CR;
            end
            RX_CR: begin
              rx_st <= (rx_data == `NSC_CH_CR) ? RX_LF : RX_IDLE;
            end
            RX_LF: begin
              rx_st <= RX_IDLE;
              if (rx_data == `NSC_CH_LF)
                pkt_done <= 1'b1;
            end
            default: rx_st <= RX_IDLE;
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  logic [1:0] flag;
  logic       ok_frame;
  logic       known;
  assign ok_frame = !rx_bad && (rx_ck == rx_sum);
  assign known = (rx_type == `NSC_PT_TEST) || (rx_type == `NSC_PT_ACK)
              || (rx_type == `NSC_PT_SYSMSG) || (rx_type == `NSC_PT_OUTSET)
              || (rx_type == `NSC_PT_FWQRY);
  always_comb begin
    if (!ok_frame)
      flag = `NSC_F_INVALID;
    else if (!known)
      flag = `NSC_F_UNSUPP;
    else if (rx_type == `NSC_PT_OUTSET && rx_fld < 4'h2)
      flag = `NSC_F_FAIL;
    else
      flag = `NSC_F_OK;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rate_track <= 8'h01;
      rate_time  <= 8'h01;
    end else if (pkt_done && ok_frame && rx_type == `NSC_PT_OUTSET && rx_fld >= 4'h2) begin
      rate_track <= 8'(rx_p0 - `NSC_CH_ZERO);
      rate_time  <= 8'(rx_p1 - `NSC_CH_ZERO);
    end
  end

  // ----------------------------------------
  // sentence scheduling
  // ----------------------------------------
  logic [31:0] pps_cnt;
  logic        pps_arm;
  logic [7:0]  sec_cnt_t;
  logic [7:0]  sec_cnt_z;
  logic        ack_pend;
  logic        fw_pend;
  logic        vtg_pend;
  logic        zda_pend;
  logic [9:0]  ack_type;
  logic [1:0]  ack_flag;
  logic        zda_go;
  logic        vtg_go;
  logic        job_start;
  nsc_job_t    next_job;
  assign zda_go = pps_arm && (pps_cnt >= 32'(TD_MIN)) && (sec_cnt_z == 8'h00) && (rate_time != 8'h00);
  assign vtg_go = pulse_per_second && (sec_cnt_t == 8'h00) && (rate_track != 8'h00);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pps_cnt   <= 32'h0;
      pps_arm   <= 1'b0;
      sec_cnt_t <= 8'h00;
      sec_cnt_z <= 8'h00;
    end else begin
      if (pulse_per_second) begin
        pps_cnt   <= 32'h0;
        pps_arm   <= 1'b1;
        sec_cnt_t <= (sec_cnt_t + 8'h01 >= rate_track) ? 8'h00 : sec_cnt_t + 8'h01;
      end else if (pps_arm) begin
        pps_cnt <= pps_cnt + 32'h1;
        // one time slot per second, the rate divider always advances
        if (pps_cnt >= 32'(TD_MIN)) begin
          pps_arm   <= 1'b0;
          sec_cnt_z <= (sec_cnt_z + 8'h01 >= rate_time) ? 8'h00 : sec_cnt_z + 8'h01;
        end
      end
    end
  end

  // pending job flags, set wins over clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ack_pend <= 1'b0;
      fw_pend  <= 1'b0;
      vtg_pend <= 1'b0;
      zda_pend <= 1'b0;
      ack_type <= 10'h000;
      ack_flag <= 2'h0;
    end else begin
      // clear the job that is being started
      if (job_start && next_job == JOB_ACK)
        ack_pend <= 1'b0;
      if (job_start && next_job == JOB_FW)
        fw_pend <= 1'b0;
      if (job_start && next_job == JOB_VTG)
        vtg_pend <= 1'b0;
      if (job_start && next_job == JOB_ZDA)
        zda_pend <= 1'b0;
      if (pkt_done) begin
        ack_pend <= 1'b1;
        ack_type <= rx_type;
        ack_flag <= flag;
        if (ok_frame && rx_type == `NSC_PT_FWQRY)
          fw_pend <= 1'b1;
      end
      if (vtg_go)
        vtg_pend <= 1'b1;
      if (zda_go)
        zda_pend <= 1'b1;
    end
  end

  // ----------------------------------------
  // sentence builder
  // ----------------------------------------
  logic [7:0]  txt [0:63];
  logic [5:0]  nbody;
  logic [5:0]  tx_idx;
  logic [5:0]  tx_end;
  logic [7:0]  tx_sum;
  logic        busy;
  logic [71:0] tsel;
  logic [7:0]  body [0:63];

  function automatic logic [7:0] hexch(input logic [3:0] v);
    hexch = (v < 4'ha) ? 8'(v) + `NSC_CH_ZERO : 8'(v) + 8'h37;
  endfunction

  // priority: ack, firmware, time, track
  always_comb begin
    if (ack_pend)
      next_job = JOB_ACK;
    else if (fw_pend)
      next_job = JOB_FW;
    else if (zda_pend)
      next_job = JOB_ZDA;
    else if (vtg_pend)
      next_job = JOB_VTG;
    else
      next_job = JOB_NONE;
  end
  assign job_start = !busy && (next_job != JOB_NONE);
  assign tsel = utc_known ? utc_time : gps_time;

  // sentence body text between dollar and star
  always_comb begin
    for (int i = 0; i < 64; i++)
      body[i] = `NSC_CH_COMMA;
    nbody = 6'd0;
    case (next_job)
      JOB_ACK, JOB_FW: begin
        {body[0], body[1], body[2], body[3]} = `NSC_TALKER;
        if (next_job == JOB_ACK) begin
          {body[4], body[5], body[6]} = {`NSC_CH_ZERO, `NSC_CH_ZERO, 8'h31};
          body[8]  = `NSC_CH_ZERO + 8'(ack_type / 10'd100);
          body[9]  = `NSC_CH_ZERO + 8'((ack_type / 10'd10) % 10'd10);
          body[10] = `NSC_CH_ZERO + 8'(ack_type % 10'd10);
          body[12] = `NSC_CH_ZERO + 8'(ack_flag);
          nbody    = 6'd13;
        end else begin
          {body[4], body[5], body[6]} = {8'h37, `NSC_CH_ZERO, 8'h35};
          for (int i = 0; i < FWLEN; i++)
            body[8+i] = fw_chars[8*(FWLEN-1-i) +: 8];
          nbody = 6'(8 + FWLEN);
        end
      end
      // track and speed, blank without fix
      JOB_VTG: begin
        {body[0], body[1], body[2], body[3], body[4]} = 40'h4750_5654_47;
        if (fix_valid) begin
          for (int i = 0; i < 5; i++) begin
            body[6+i]  = course_true[8*(4-i) +: 8];
            body[14+i] = course_mag[8*(4-i) +: 8];
            body[22+i] = speed_knots[8*(4-i) +: 8];
            body[30+i] = speed_kmh[8*(4-i) +: 8];
          end
          {body[12], body[20], body[28], body[36]} = 32'h544d_4e4b;
          body[38] = mode_char;
          nbody    = 6'd39;
        end else begin
          // empty fields, unit letters kept, mode not valid
          {body[7], body[10], body[13], body[16]} = 32'h544d_4e4b;
          body[18] = 8'h4e;
          nbody    = 6'd19;
        end
      end
      JOB_ZDA: begin
        {body[0], body[1], body[2], body[3], body[4]} = 40'h4750_5a44_41;
        for (int i = 0; i < 9; i++)
          body[6+i] = tsel[8*(8-i) +: 8];
        {body[16], body[17]} = day_chars;
        {body[19], body[20]} = month_chars;
        {body[22], body[23], body[24], body[25]} = year_chars;
        nbody = 6'd28;
      end
      default: nbody = 6'd0;
    endcase
  end

  // framing: dollar, body, star, checksum, cr lf
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy   <= 1'b0;
      tx_idx <= 6'd0;
      tx_end <= 6'd0;
      for (int i = 0; i < 64; i++)
        txt[i] <= 8'h00;
    end else if (job_start) begin
      busy   <= 1'b1;
      tx_idx <= 6'd0;
      tx_end <= 6'(nbody + 6'd5);
      txt[0] <= `NSC_CH_DOLLAR;
      for (int i = 0; i < 58; i++)
        txt[i+1] <= (6'(i) < nbody) ? body[i] : 8'h00;
    end else if (busy && tx_ready) begin
      if (tx_idx == tx_end)
        busy <= 1'b0;
      tx_idx <= tx_idx + 6'd1;
    end
  end

  always_comb begin
    tx_sum = 8'h00;
    for (int i = 1; i < 59; i++)
      if (6'(i) <= tx_end - 6'd5)
        tx_sum = tx_sum ^ txt[i];
  end

  // byte selection for the stream
  always_comb begin
    tx_valid = busy;
    if (tx_idx <= tx_end - 6'd5)
      tx_data = txt[tx_idx];
    else if (tx_idx == tx_end - 6'd4)
      tx_data = `NSC_CH_STAR;
    else if (tx_idx == tx_end - 6'd3)
      tx_data = hexch(tx_sum[7:4]);
    else if (tx_idx == tx_end - 6'd2)
      tx_data = hexch(tx_sum[3:0]);
    else if (tx_idx == tx_end - 6'd1)
      tx_data = `NSC_CH_CR;
    else
      tx_data = `NSC_CH_LF;
  end

endmodule // nsc_port

// ---- nsc_port_assertions.sv ----
`timescale 1ns/10ps
module nsc_port_chk #(
  parameter int TD_MAX = 100
) (
  // clock and reset
  input wire logic       clock,
  input wire logic       arst_n,
  // byte streams
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  // timing and settings
  input wire logic       pulse_per_second,
  input wire logic [7:0] rate_track,
  input wire logic [7:0] rate_time
);
  logic in_pkt;
  logic last_cr;
  logic pend;
  int   cnt;
  int   since_lf;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  // receive framing: inside a packet, last byte cr
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      in_pkt  <= 1'b0;
      last_cr <= 1'b0;
    end else if (rx_valid) begin
      in_pkt  <= (rx_data == 8'h24) || (in_pkt && rx_data != 8'h0a);
      last_cr <= (rx_data == 8'h0d);
    end
  end
  // cycles since the last received lf
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      since_lf <= 0;
    end else if (rx_valid && rx_data == 8'h0a) begin
      since_lf <= 0;
    end else if (since_lf < 100) begin
      since_lf <= since_lf + 1;
    end
  end
  // wait from pulse to the time sentence, marked by its z byte
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pend <= 1'b0;
      cnt  <= 0;
    end else if (pulse_per_second && rate_time == 8'h01) begin
      pend <= 1'b1;
      cnt  <= 0;
    end else if (tx_valid && tx_ready && tx_data == 8'h5a) begin
      pend <= 1'b0;
    end else if (pend) begin
      cnt  <= cnt + 1;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_stall_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx byte changed while stalled");
  a_start_dollar: assert property ($rose(tx_valid) |-> tx_data == 8'h24)
    else $error("packet does not open with dollar");
  a_ack_start: assert property (rx_valid && rx_data == 8'h0a && last_cr && in_pkt && !tx_valid |-> ##3 tx_valid && tx_data == 8'h24)
    else $error("ack did not start three cycles after lf");
  a_star_hex: assert property (tx_valid && tx_ready && tx_data == 8'h2a |=> tx_valid && (tx_data inside {[8'h30:8'h39], [8'h41:8'h46]}))
    else $error("checksum char not uppercase hex");
  a_cr_lf: assert property (tx_valid && tx_ready && tx_data == 8'h0d |=> tx_valid && tx_data == 8'h0a)
    else $error("cr not followed by lf");
  a_lf_next: assert property (tx_valid && tx_ready && tx_data == 8'h0a |=> !tx_valid)
    else $error("packet did not end after lf");
  a_rate_reset: assert property ($rose(arst_n) |-> rate_track == 8'h01 && rate_time == 8'h01 && !tx_valid)
    else $error("reset state of rates or tx wrong");
  a_rates_quiet: assert property (since_lf > 8 |=> $stable(rate_track) && $stable(rate_time))
    else $error("rates changed without a command");
  a_time_bound: assert property (pend |-> cnt <= TD_MAX)
    else $error("time sentence later than allowed");
  // main scenarios
  c_ack: cover property (rx_valid && rx_data == 8'h0a && last_cr && in_pkt);
  c_pulse: cover property (pulse_per_second && rate_time == 8'h01);
  c_stall: cover property (tx_valid && !tx_ready);
endmodule // nsc_port_chk

bind nsc_port nsc_port_chk #(.TD_MAX(TD_MAX)) u_chk (
  .clock(clock), .arst_n(arst_n), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .pulse_per_second(pulse_per_second),
  .rate_track(rate_track), .rate_time(rate_time));

// ---- nsc_host.sv ----
`timescale 1ns/10ps
module nsc_host (
  // clock
  input  wire logic       clock,
  // bytes to the device
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  // bytes from the device
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  // stall enable
  input  wire logic       slow
);
  string cur;
  string lines[$];
  // idle lines at time zero
  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
    cur      = "";
  end
  // dollar, talker, three-digit type, star, checksum, cr lf
  function automatic string pkt(input string body);
    logic [7:0] c;
    string      h;
    c = 8'h00;
    h = "00";
    foreach (body[i]) c ^= body[i];
    h[0] = (c[7:4] < 10) ? 8'h30 + c[7:4] : 8'h37 + c[7:4];
    h[1] = (c[3:0] < 10) ? 8'h30 + c[3:0] : 8'h37 + c[3:0];
    return {"$", body, "*", h, "\r\n"};
  endfunction
  // bytes back to back, line released after
  task automatic send(input string s);
    foreach (s[i]) begin
      @(posedge clock);
      #2 rx_data = s[i];
      rx_valid = 1'b1;
    end
    @(posedge clock);
    #2 rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask
  // collect device lines, random stalls when slow
  always @(posedge clock) begin
    if (tx_valid && tx_ready) begin
      cur = {cur, string'(tx_data)};
      if (tx_data == 8'h0a) begin
        lines.push_back(cur);
        cur = "";
      end
    end
    #2 tx_ready = slow ? 1'($urandom_range(0, 1)) : 1'b1;
  end
endmodule // nsc_host

// ---- tb.sv ----
`timescale 1ns/10ps
module tb;
  import nsc_pkg::*;
  localparam int TDMIN = 20;
  localparam int TDMAX = 400;
  logic        clock, arst_n, rx_valid, tx_valid, tx_ready, slow, fix_valid, utc_known, pulse_per_second;
  logic [7:0]  rx_data, tx_data, mode_char, rate_track, rate_time;
  logic [39:0] course_true, course_mag, speed_knots, speed_kmh;
  logic [71:0] utc_time, gps_time;
  logic [15:0] day_chars, month_chars;
  logic [31:0] year_chars, fw_chars;
  int          err_total, n_tests;
  // ----------------------------------------
  // device and host
  // ----------------------------------------
  nsc_port #(.TD_MIN(TDMIN), .TD_MAX(TDMAX), .FWLEN(4)) dut (
    .clock(clock), .arst_n(arst_n), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .fix_valid(fix_valid), .mode_char(mode_char),
    .course_true(course_true), .course_mag(course_mag), .speed_knots(speed_knots), .speed_kmh(speed_kmh),
    .utc_time(utc_time), .gps_time(gps_time), .utc_known(utc_known), .day_chars(day_chars),
    .month_chars(month_chars), .year_chars(year_chars), .pulse_per_second(pulse_per_second),
    .fw_chars(fw_chars), .rate_track(rate_track), .rate_time(rate_time));
  nsc_host host (.clock(clock), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow));
  // clock and watchdog
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    #(20 * 60000);
    err_total++;
    finish_test();
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string what, input string exp, input string got);
    n_tests++;
    if (got != exp) begin
      err_total++;
      $display("ERROR %s expected %s seen %s", what, exp, got);
    end
  endtask
  function automatic bit has(string s, string n);
    for (int i = 0; i + n.len() <= s.len(); i++) if (s.substr(i, i + n.len() - 1) == n) return 1;
    return 0;
  endfunction
  function automatic string digits(int n);
    string s;
    byte   b;
    s = "";
    repeat (n) begin
      b = 8'h30 + 8'($urandom_range(0, 9));
      s = {s, string'(b)};
    end
    return s;
  endfunction
  function automatic logic [71:0] pack(string s);
    logic [71:0] v;
    v = '0;
    foreach (s[i]) v = {v[63:0], s[i]};
    return v;
  endfunction
  // wait for a line holding the needle, then recheck its frame
  task automatic find(input string nd, output string got);
    got = "none";
    for (int t = 0; t < 3000 && got == "none"; t++) begin
      @(posedge clock);
      foreach (host.lines[k]) if (has(host.lines[k], nd)) got = host.lines[k];
    end
    for (int k = 1; k < got.len(); k++) if (got[k] == 8'h2a) check("frame", host.pkt(got.substr(1, k - 1)), got);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    string cmd[8], ack[8], got, nd, tn, ct, cm, sk, sh, dd, mm, yy, ml, lng;
    {arst_n, slow, fix_valid, utc_known, pulse_per_second} = '0;
    {mode_char, course_true, course_mag, speed_knots, speed_kmh, utc_time, gps_time} = '0;
    {day_chars, month_chars, year_chars} = '0;
    fw_chars = pack("V123");
    void'($urandom(32'h7513));
    lng = "XPRT000";
    repeat (130) lng = {lng, ",1"};
    cmd = '{host.pkt("XPRT000"), host.pkt("XPRT123,4"), host.pkt("XPRT314,5,7"), host.pkt("XPRT314"),
            "$XPRT000*00\r\n", host.pkt(lng), host.pkt("XPRT010,1"), host.pkt("XPRT314,1,1")};
    ack = '{"000,3", "123,1", "314,3", "314,2", "000,0", "000,0", "010,3", "314,3"};
    repeat (20) @(posedge clock);
    #2 arst_n = 1'b1;
    // command table, stalls on odd entries
    foreach (cmd[i]) begin
      slow = i[0];
      host.lines.delete();
      host.send(cmd[i]);
      nd = host.pkt({"XPRT001,", ack[i]});
      find(nd, got);
      check("ack", nd, got);
      if (i == 2 || i == 3) begin
        check("rate_track", "5", $sformatf("%0h", rate_track));
        check("rate_time", "7", $sformatf("%0h", rate_time));
      end
      $display("command test %0d done", i);
    end
    // firmware query: ack then info packet
    host.lines.delete();
    host.send(host.pkt("XPRT605"));
    find(host.pkt("XPRT001,605,3"), got);
    check("fw ack", host.pkt("XPRT001,605,3"), got);
    find("$XPRT705", got);
    check("fw info", "1", $sformatf("%0d", has(got, "V123")));
    $display("firmware test done");
    // pulse driven sentences, last one without fix
    ml = "ADEMSN";
    for (int i = 0; i < 3; i++) begin
      ct = digits(5);
      cm = digits(5);
      sk = digits(5);
      sh = digits(5);
      dd = $sformatf("%02d", $urandom_range(1, 31));
      mm = $sformatf("%02d", $urandom_range(1, 12));
      yy = digits(4);
      tn = digits(9);
      @(posedge clock);
      #2 fix_valid = (i < 2);
      utc_known = i[0];
      mode_char = ml[$urandom_range(0, 5)];
      course_true = 40'(pack(ct));
      course_mag = 40'(pack(cm));
      speed_knots = 40'(pack(sk));
      speed_kmh = 40'(pack(sh));
      utc_time = utc_known ? pack(tn) : ~pack(tn);
      gps_time = utc_known ? ~pack(tn) : pack(tn);
      day_chars = 16'(pack(dd));
      month_chars = 16'(pack(mm));
      year_chars = 32'(pack(yy));
      host.lines.delete();
      pulse_per_second = 1'b1;
      @(posedge clock);
      #2 pulse_per_second = 1'b0;
      nd = {",", tn, ",", dd, ",", mm, ",", yy, ",,*"};
      find(nd, got);
      check("time sentence", "1", $sformatf("%0d", has(got, nd)));
      if (fix_valid) begin
        nd = {",", ct, ",T,", cm, ",M,", sk, ",N,", sh, ",K,", string'(mode_char), "*"};
        find(nd, got);
        check("track sentence", "1", $sformatf("%0d", has(got, nd)));
      end else begin
        nd = "$GPVTG,,T,,M,,N,,K,N*";
        find(nd, got);
        check("blank track sentence", "1", $sformatf("%0d", has(got, nd)));
      end
      $display("sentence test %0d done", i);
    end
    finish_test();
  end
endmodule // tb
